// ---- design/exec_params.svh ----
// Offsets, field positions, reset values and sizes of the execution unit
`ifndef EXEC_PARAMS_SVH
`define EXEC_PARAMS_SVH

`define ADDR_INSTR 8'h00
`define ADDR_TARGET 8'h04
`define ADDR_MEMOP 8'h08
`define ADDR_PC 8'h0C
`define ADDR_FLAGS 8'h10
`define ADDR_DMSTORE 8'h14
`define ADDR_STACK 8'h18
`define ADDR_REGS 2'b01
`define INSTR_W 28
`define STACK_DEPTH 8
`define NUM_REGS 16
`define IDX_IPH 4'hC
`define IDX_IPL 4'hD
`define IDX_STAT 4'hE
`define IDX_ACC 4'hF
`define GIE_BIT 5
`define PC_RESET 16'h0000
`define REG_RESET 8'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define STRB_ALL 4'hF

`endif

// ---- design/exec_pkg.sv ----
// Types shared by the execution unit
package exec_pkg;

	typedef enum logic [5:0] {
		op_nop, op_jump, op_jump_ip, op_jcc, op_jcc_ip, op_call, op_call_ip,
		op_calls, op_calls_ip, op_ret, op_rets, op_reti, op_push, op_pop,
		op_move_imm, op_move, op_move_to_dm, op_move_imm_dm, op_cmvd,
		op_cmvs, op_lsl_zero_fill, op_lsl_carry, op_shr, op_shr_carry,
		op_shr_arith, op_ones_complement, op_twos_complement,
		op_twos_complement_chain, op_inc, op_inc_carry, op_dec
	} op_t;

	typedef enum logic [3:0] {
		cc_always, cc_c, cc_nc, cc_z, cc_nz, cc_v, cc_nv
	} cond_t;

	// Instruction word as written by software
	typedef struct packed {
		cond_t cc;
		logic [7:0] data8;
		logic [3:0] src;
		logic [3:0] dst;
		logic from_mem;
		logic [0:0] spare;
		op_t op;
	} instr_t;

	typedef struct packed {
		logic v;
		logic c;
		logic z;
	} flags_t;

endpackage

// ---- design/exec_unit.sv ----
// Branch, stack, move, shift and increment execution unit with AXI4-Lite
`timescale 1ns/1ps
`include "exec_params.svh"
`default_nettype none

module exec_unit
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// ----------------------------------------------------------------
	// Bus write side
	// ----------------------------------------------------------------
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic aw_fire;
	logic w_fire;
	logic do_write;
	logic next_aw_held;
	logic next_w_held;
	logic next_bvalid;
	logic [7:0] waddr;
	logic [31:0] wdata;
	logic [3:0] wstrb;
	logic w_mapped;

	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [31:0] nw, input logic [3:0] st);
		logic [15:0] r;
		r = old;
		for (int b = 0; b < 2; b++)
		begin
			if (st[b])
				r[8*b +: 8] = nw[8*b +: 8];
		end
		return r;
	endfunction

	assign aw_fire = s_axi_awvalid & s_axi_awready;
	assign w_fire = s_axi_wvalid & s_axi_wready;
	assign waddr = aw_held ? aw_addr : s_axi_awaddr;
	assign wdata = w_held ? w_data : s_axi_wdata;
	assign wstrb = w_held ? w_strb : s_axi_wstrb;
	assign do_write = (aw_held | aw_fire) & (w_held | w_fire) & ~s_axi_bvalid;
	assign next_aw_held = (aw_held | aw_fire) & ~do_write;
	assign next_w_held = (w_held | w_fire) & ~do_write;
	assign next_bvalid = do_write | (s_axi_bvalid & ~s_axi_bready);
	assign w_mapped = (waddr[7:6] == `ADDR_REGS) || waddr == `ADDR_INSTR ||
		waddr == `ADDR_TARGET || waddr == `ADDR_MEMOP ||
		waddr == `ADDR_PC || waddr == `ADDR_FLAGS;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end
		else
		begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			if (aw_fire)
				aw_addr <= s_axi_awaddr;
			if (w_fire)
			begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			// Each channel is ready only while its own beat is not held and no response waits, so one write at a time
			s_axi_awready <= ~next_aw_held & ~next_bvalid;
			s_axi_wready <= ~next_w_held & ~next_bvalid;
			s_axi_bvalid <= next_bvalid;
			if (do_write)
				s_axi_bresp <= w_mapped ? `RESP_OKAY : `RESP_SLVERR;
		end
	end

	// ----------------------------------------------------------------
	// Architectural state
	// ----------------------------------------------------------------
	logic [7:0] regs [`NUM_REGS];
	logic [7:0] next_regs [`NUM_REGS];
	logic [15:0] stack [`STACK_DEPTH];
	logic [15:0] pc;
	logic [15:0] next_pc;
	logic [15:0] pc_plus1;
	logic [15:0] target;
	logic [7:0] mem_operand;
	logic [15:0] dm_store;
	logic [15:0] next_dm_store;
	exec_pkg::flags_t flags;
	exec_pkg::flags_t next_flags;
	exec_pkg::instr_t cur;
	exec_pkg::instr_t last_instr;
	logic exec;
	logic push;
	logic pop;
	logic [15:0] push_val;
	logic [15:0] ip;
	logic [7:0] src;
	logic [7:0] res;
	logic cc_true;

	assign cur = exec_pkg::instr_t'(wdata[`INSTR_W-1:0]);
	// Partial-lane writes to the instruction word are ignored
	assign exec = do_write && waddr == `ADDR_INSTR && wstrb == `STRB_ALL;
	assign pc_plus1 = pc + 16'h0001;
	assign ip = {regs[`IDX_IPH], regs[`IDX_IPL]};
	assign src = cur.from_mem ? mem_operand : regs[cur.src];

	always_comb
	begin
		unique case (cur.cc)
			exec_pkg::cc_always: cc_true = 1'b1;
			exec_pkg::cc_c: cc_true = flags.c;
			exec_pkg::cc_nc: cc_true = ~flags.c;
			exec_pkg::cc_z: cc_true = flags.z;
			exec_pkg::cc_nz: cc_true = ~flags.z;
			exec_pkg::cc_v: cc_true = flags.v;
			exec_pkg::cc_nv: cc_true = ~flags.v;
			default: cc_true = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// Instruction execution, one per instruction write
	// ----------------------------------------------------------------
	always_comb
	begin
		logic wr_dst;
		logic wr_acc;
		wr_dst = 1'b0;
		wr_acc = 1'b0;
		res = 8'h00;
		next_regs = regs;
		next_pc = pc;
		next_flags = flags;
		next_dm_store = dm_store;
		push = 1'b0;
		pop = 1'b0;
		push_val = ip;
		if (exec)
		begin
			next_pc = pc_plus1;
			unique case (cur.op)
				exec_pkg::op_jump: next_pc = target;
				exec_pkg::op_jump_ip: next_pc = ip;
				exec_pkg::op_jcc: next_pc = cc_true ? target : pc_plus1;
				exec_pkg::op_jcc_ip: next_pc = cc_true ? ip : pc_plus1;
				exec_pkg::op_call, exec_pkg::op_call_ip:
				begin
					push = 1'b1;
					push_val = pc_plus1;
					next_pc = (cur.op == exec_pkg::op_call) ? target : ip;
				end
				exec_pkg::op_calls, exec_pkg::op_calls_ip:
				begin
					next_regs[`IDX_IPH] = pc_plus1[15:8];
					next_regs[`IDX_IPL] = pc_plus1[7:0];
					next_pc = (cur.op == exec_pkg::op_calls) ? target : ip;
				end
				exec_pkg::op_ret:
				begin
					next_pc = stack[0];
					pop = 1'b1;
				end
				exec_pkg::op_rets: next_pc = ip;
				exec_pkg::op_reti:
				begin
					next_pc = stack[0];
					pop = 1'b1;
					next_regs[`IDX_STAT][`GIE_BIT] = 1'b1;
				end
				exec_pkg::op_push: push = 1'b1;
				exec_pkg::op_pop:
				begin
					pop = 1'b1;
					next_regs[`IDX_IPH] = stack[0][15:8];
					next_regs[`IDX_IPL] = stack[0][7:0];
				end
				exec_pkg::op_move_imm, exec_pkg::op_move:
				begin
					res = (cur.op == exec_pkg::op_move) ? src : cur.data8;
					wr_dst = 1'b1;
					wr_acc = 1'b1;
				end
				// Stores only report the address and the written byte; no flag moves
				exec_pkg::op_move_to_dm:
					next_dm_store = {cur.data8, regs[cur.dst]};
				exec_pkg::op_move_imm_dm:
					next_dm_store = {target[7:0], cur.data8};
				exec_pkg::op_cmvd, exec_pkg::op_cmvs:
				begin
					res = src;
					wr_acc = 1'b1;
					wr_dst = (cur.op == exec_pkg::op_cmvd) ? ~flags.c : flags.c;
				end
				exec_pkg::op_lsl_zero_fill, exec_pkg::op_lsl_carry:
				begin
					res = {src[6:0], cur.op == exec_pkg::op_lsl_carry && flags.c};
					next_flags.c = src[7];
					next_flags.v = res[7] ^ src[7];
					wr_dst = 1'b1;
					wr_acc = 1'b1;
				end
				exec_pkg::op_shr, exec_pkg::op_shr_carry, exec_pkg::op_shr_arith:
				begin
					res = {src[7], src[7:1]};
					if (cur.op == exec_pkg::op_shr)
						res[7] = 1'b0;
					if (cur.op == exec_pkg::op_shr_carry)
						res[7] = flags.c;
					next_flags.c = src[0];
					next_flags.v = res[7] ^ src[7];
					wr_dst = 1'b1;
					wr_acc = 1'b1;
				end
				exec_pkg::op_ones_complement:
				begin
					res = ~src;
					wr_dst = 1'b1;
					wr_acc = 1'b1;
				end
				exec_pkg::op_twos_complement:
				begin
					res = ~src + 8'h01;
					next_flags.c = (res == 8'h00);
					next_flags.v = (src == 8'h80);
					wr_dst = 1'b1;
					wr_acc = 1'b1;
				end
				exec_pkg::op_twos_complement_chain:
				begin
					res = ~src + {7'h00, flags.c};
					next_flags.c = (res == 8'h00) && flags.c;
					next_flags.v = (src == 8'h80) && flags.c;
					wr_dst = 1'b1;
					wr_acc = 1'b1;
				end
				exec_pkg::op_inc:
				begin
					res = src + 8'h01;
					next_flags.c = (res == 8'h00);
					next_flags.v = (src == 8'h7F);
					wr_dst = 1'b1;
					wr_acc = 1'b1;
				end
				exec_pkg::op_inc_carry:
				begin
					res = src + {7'h00, flags.c};
					next_flags.c = (res == 8'h00) && flags.c;
					next_flags.v = (src == 8'h7F) && flags.c;
					wr_dst = 1'b1;
					wr_acc = 1'b1;
				end
				exec_pkg::op_dec:
				begin
					res = src - 8'h01;
					next_flags.c = (res != 8'hFF);
					next_flags.v = (src == 8'h80);
					wr_dst = 1'b1;
					wr_acc = 1'b1;
				end
				default: next_pc = pc_plus1;
			endcase
			if (wr_dst)
				next_regs[cur.dst] = res;
			if (wr_acc)
			begin
				next_regs[`IDX_ACC] = res;
				next_flags.z = (res == 8'h00);
			end
		end
		else if (do_write && waddr[7:6] == `ADDR_REGS && wstrb[0])
			next_regs[waddr[5:2]] = wdata[7:0];
		else if (do_write && waddr == `ADDR_PC)
			next_pc = merge(pc, wdata, wstrb);
		else if (do_write && waddr == `ADDR_FLAGS && wstrb[0])
			next_flags = exec_pkg::flags_t'(wdata[2:0]);
	end

	genvar gi;
	generate
		for (gi = 0; gi < `NUM_REGS; gi++)
		begin : g_regs
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					regs[gi] <= `REG_RESET;
				else
					regs[gi] <= next_regs[gi];
			end
		end
		for (gi = 0; gi < `STACK_DEPTH; gi++)
		begin : g_stack
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					stack[gi] <= `PC_RESET;
				else if (push)
					stack[gi] <= (gi == 0) ? push_val : stack[(gi + `STACK_DEPTH - 1) % `STACK_DEPTH];
				else if (pop)
					stack[gi] <= (gi == `STACK_DEPTH - 1) ? `PC_RESET : stack[(gi + 1) % `STACK_DEPTH];
			end
		end
	endgenerate

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pc <= `PC_RESET;
			flags <= '0;
			dm_store <= 16'h0000;
			target <= 16'h0000;
			mem_operand <= 8'h00;
			last_instr <= '0;
		end
		else
		begin
			pc <= next_pc;
			flags <= next_flags;
			dm_store <= next_dm_store;
			if (exec)
				last_instr <= cur;
			if (do_write && waddr == `ADDR_TARGET)
				target <= merge(target, wdata, wstrb);
			if (do_write && waddr == `ADDR_MEMOP && wstrb[0])
				mem_operand <= wdata[7:0];
		end
	end

	// ----------------------------------------------------------------
	// Bus read side
	// ----------------------------------------------------------------
	logic ar_fire;
	logic next_rvalid;

	assign ar_fire = s_axi_arvalid & s_axi_arready;
	assign next_rvalid = ar_fire | (s_axi_rvalid & ~s_axi_rready);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= ~next_rvalid;
			s_axi_rvalid <= next_rvalid;
			if (ar_fire)
			begin
				s_axi_rresp <= `RESP_OKAY;
				s_axi_rdata <= 32'h00000000;
				if (s_axi_araddr[7:6] == `ADDR_REGS)
					s_axi_rdata <= {24'h000000, regs[s_axi_araddr[5:2]]};
				else if (s_axi_araddr == `ADDR_INSTR)
					s_axi_rdata <= {4'h0, last_instr};
				else if (s_axi_araddr == `ADDR_TARGET)
					s_axi_rdata <= {16'h0000, target};
				else if (s_axi_araddr == `ADDR_MEMOP)
					s_axi_rdata <= {24'h000000, mem_operand};
				else if (s_axi_araddr == `ADDR_PC)
					s_axi_rdata <= {16'h0000, pc};
				else if (s_axi_araddr == `ADDR_FLAGS)
					s_axi_rdata <= {16'h0000, regs[`IDX_ACC], 5'h00, flags};
				else if (s_axi_araddr == `ADDR_DMSTORE)
					s_axi_rdata <= {16'h0000, dm_store};
				else if (s_axi_araddr == `ADDR_STACK)
					s_axi_rdata <= {16'h0000, stack[0]};
				else
					s_axi_rresp <= `RESP_SLVERR;
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic is_alu;
	assign is_alu = exec && cur.op inside {exec_pkg::op_move,
		exec_pkg::op_inc, exec_pkg::op_dec, exec_pkg::op_lsl_zero_fill,
		exec_pkg::op_ones_complement, exec_pkg::op_shr};

	a_jump_target: assert property (exec && cur.op == exec_pkg::op_jump |=> pc == $past(target)) else $error("jump target not loaded");
	a_jcc_fall: assert property (exec && cur.op == exec_pkg::op_jcc && !cc_true |=> pc == $past(pc_plus1)) else $error("false jcc did not fall through");
	a_call_push: assert property (exec && cur.op == exec_pkg::op_call |=> stack[0] == $past(pc_plus1) && stack[1] == $past(stack[0])) else $error("call push wrong");
	a_calls_link: assert property (exec && cur.op == exec_pkg::op_calls |=> ip == $past(pc_plus1)) else $error("shallow call link wrong");
	a_ret_pop: assert property (exec && cur.op == exec_pkg::op_ret |=> pc == $past(stack[0]) && flags == $past(flags) && stack[0] == $past(stack[1])) else $error("return pop wrong");
	a_reti_gie: assert property (exec && cur.op == exec_pkg::op_reti |=> regs[`IDX_STAT][`GIE_BIT]) else $error("reti left interrupts off");
	a_zero_flag: assert property (is_alu |=> flags.z == (regs[`IDX_ACC] == 8'h00)) else $error("zero flag mismatch");
	a_lsl_carry: assert property (exec && cur.op == exec_pkg::op_lsl_zero_fill |=> regs[`IDX_ACC] == {$past(src[6:0]), 1'b0} && flags.c == $past(src[7])) else $error("left shift wrong");
	a_inc_carry: assert property (exec && cur.op == exec_pkg::op_inc |=> flags.c == (regs[`IDX_ACC] == 8'h00)) else $error("increment carry wrong");
	a_dec_carry: assert property (exec && cur.op == exec_pkg::op_dec |=> flags.c == (regs[`IDX_ACC] != 8'hFF)) else $error("decrement carry wrong");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid ##0 $stable(s_axi_bresp)) else $error("write answer dropped");

	c_call_ret: cover property (exec && cur.op == exec_pkg::op_call ##[1:20] exec && cur.op == exec_pkg::op_ret);
	c_jcc_taken: cover property (exec && cur.op == exec_pkg::op_jcc && cc_true);
	c_inc_wrap: cover property (exec && cur.op == exec_pkg::op_inc && src == 8'hFF);

endmodule

`default_nettype wire

// ---- verification/risc8_branch_shift_arith_exec_tb.sv ----
// Self-checking testbench for the branch, stack, shift and increment unit
`timescale 1ns/1ps
`include "exec_params.svh"
`default_nettype none

module risc8_branch_shift_arith_exec_tb;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h00000000;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	int fail_count = 0;
	int total_checks = 0;
	integer seed = 32'h4BA76885;
	logic [31:0] r;
	logic [31:0] d;
	logic [15:0] p, t, q;
	logic [7:0] x;
	logic [10:0] m;
	logic [15:0] vals [9];
	logic [7:0] corners [4] = '{8'h00, 8'hFF, 8'h7F, 8'h80};
	exec_pkg::op_t alu_ops [14] = '{exec_pkg::op_move, exec_pkg::op_cmvd,
		exec_pkg::op_cmvs, exec_pkg::op_lsl_zero_fill, exec_pkg::op_lsl_carry,
		exec_pkg::op_shr, exec_pkg::op_shr_carry, exec_pkg::op_shr_arith,
		exec_pkg::op_ones_complement, exec_pkg::op_twos_complement,
		exec_pkg::op_twos_complement_chain, exec_pkg::op_inc,
		exec_pkg::op_inc_carry, exec_pkg::op_dec};

	always #4 aclk = ~aclk;

	exec_unit dut
	(
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready
	);

	// ----------------------------------------------------------------
	// Comparisons and bus cycles
	// ----------------------------------------------------------------
	task automatic check_word(input string what, input logic [31:0] e,
		input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic check_resp(input string what, input logic [1:0] e,
		input logic [1:0] g);
		total_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic final_report();
		$display("Checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Both channels are offered together; each is released once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] wd,
		input logic [1:0] er);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= wd;
		s_axi_wstrb <= `STRB_ALL;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_done && w_done))
		begin
			@(posedge aclk);
			if (!aw_done && s_axi_awready === 1'b1)
			begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_done && s_axi_wready === 1'b1)
			begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do
			@(posedge aclk);
		while (s_axi_bvalid !== 1'b1);
		check_resp("bresp", er, s_axi_bresp);
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [1:0] er,
		output logic [31:0] rd);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
			@(posedge aclk);
		while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do
			@(posedge aclk);
		while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		check_resp("rresp", er, s_axi_rresp);
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		axi_wr(a, wd, `RESP_OKAY);
	endtask

	task automatic expect_rd(input string what, input logic [7:0] a,
		input logic [31:0] e);
		logic [31:0] rd;
		axi_rd(a, `RESP_OKAY, rd);
		check_word(what, e, rd);
	endtask

	function automatic logic [7:0] reg_addr(input int i);
		return 8'h40 + 8'(4 * i);
	endfunction

	task automatic exec(input exec_pkg::op_t op, input logic [3:0] dst,
		input logic [3:0] src, input logic [7:0] d8, input logic fm,
		input logic [3:0] cc);
		exec_pkg::instr_t ins;
		ins = '0;
		ins.op = op;
		ins.dst = dst;
		ins.src = src;
		ins.data8 = d8;
		ins.from_mem = fm;
		ins.cc = exec_pkg::cond_t'(cc);
		wr(`ADDR_INSTR, {4'h0, ins});
	endtask

	task automatic set_ip(input logic [15:0] v);
		wr(reg_addr(`IDX_IPH), {24'h0, v[15:8]});
		wr(reg_addr(`IDX_IPL), {24'h0, v[7:0]});
	endtask

	task automatic expect_ip(input logic [15:0] e);
		expect_rd("ip high", reg_addr(`IDX_IPH), {24'h0, e[15:8]});
		expect_rd("ip low", reg_addr(`IDX_IPL), {24'h0, e[7:0]});
	endtask

	// ----------------------------------------------------------------
	// Expected results: {dest written, V, C, accumulator}
	// ----------------------------------------------------------------
	function automatic logic [10:0] alu_model(input exec_pkg::op_t op,
		input logic [7:0] x, input logic c, input logic v);
		logic [7:0] a;
		logic w;
		a = x;
		w = 1'b1;
		case (op)
			exec_pkg::op_cmvd: w = !c;
			exec_pkg::op_cmvs: w = c;
			exec_pkg::op_lsl_zero_fill: {c, a} = {x, 1'b0};
			exec_pkg::op_lsl_carry: {c, a} = {x, c};
			exec_pkg::op_shr: {a, c} = {1'b0, x};
			exec_pkg::op_shr_carry: {a, c} = {c, x};
			exec_pkg::op_shr_arith: {a, c} = {x[7], x};
			exec_pkg::op_ones_complement: a = ~x;
			exec_pkg::op_twos_complement:
				{a, c, v} = {~x + 8'h01, x == 8'h00, x == 8'h80};
			exec_pkg::op_twos_complement_chain:
				{a, c, v} = {~x + {7'h0, c}, c && x == 8'h00,
					c && x == 8'h80};
			exec_pkg::op_inc:
				{a, c, v} = {x + 8'h01, x == 8'hFF, x == 8'h7F};
			exec_pkg::op_inc_carry:
				{a, c, v} = {x + {7'h0, c}, c && x == 8'hFF,
					c && x == 8'h7F};
			exec_pkg::op_dec:
				{a, c, v} = {x - 8'h01, x != 8'h00, x == 8'h80};
			default: ;
		endcase
		if (op inside {[exec_pkg::op_lsl_zero_fill:exec_pkg::op_shr_arith]})
			v = a[7] ^ x[7];
		return {w, v, c, a};
	endfunction

	// Flags argument is {V, C, Z}; codes above six never branch
	function automatic logic cond_true(input logic [3:0] k,
		input logic [2:0] f);
		case (k)
			4'h0: return 1'b1;
			4'h1: return f[1];
			4'h2: return !f[1];
			4'h3: return f[0];
			4'h4: return !f[0];
			4'h5: return f[2];
			4'h6: return !f[2];
			default: return 1'b0;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Stimulus
	// ----------------------------------------------------------------
	initial
	begin
		repeat (40000) @(posedge aclk);
		fail_count++;
		final_report();
	end

	initial
	begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		expect_rd("pc", `ADDR_PC, 32'h0);
		expect_rd("flags", `ADDR_FLAGS, 32'h0);
		expect_rd("stack", `ADDR_STACK, 32'h0);
		for (int i = 0; i < 16; i++)
		begin
			expect_rd("reg reset", reg_addr(i), 32'h0);
			r = $random(seed);
			wr(reg_addr(i), {24'h0, r[7:0]});
			expect_rd("reg", reg_addr(i), {24'h0, r[7:0]});
		end
		axi_rd(8'h1C, `RESP_SLVERR, d);
		check_word("unmapped", 32'h0, d);
		axi_wr(8'h80, 32'hFFFFFFFF, `RESP_SLVERR);
		// When the memory operand is selected, register 1 holds its complement to catch a mixup
		for (int k = 0; k < 14; k++)
			for (int n = 0; n < 8; n++)
			begin
				r = $random(seed);
				x = (n < 4) ? corners[n] : r[23:16];
				wr(`ADDR_FLAGS, {29'h0, r[1], r[0], r[2]});
				wr(`ADDR_MEMOP, {24'h0, x});
				wr(reg_addr(1), {24'h0, r[3] ? ~x : x});
				wr(reg_addr(2), {24'h0, r[15:8]});
				exec(alu_ops[k], 4'h2, 4'h1, 8'h00, r[3], 4'h0);
				m = alu_model(alu_ops[k], x, r[0], r[1]);
				expect_rd("flags", `ADDR_FLAGS, {16'h0, m[7:0], 5'h0,
					m[9], m[8], m[7:0] == 8'h00});
				expect_rd("dest", reg_addr(2),
					{24'h0, m[10] ? m[7:0] : r[15:8]});
			end
		r = $random(seed);
		{p, t} = r;
		q = ~p;
		wr(`ADDR_PC, {16'h0, p});
		wr(`ADDR_TARGET, {16'h0, t});
		exec(exec_pkg::op_jump, 4'h0, 4'h0, 8'h00, 1'b0, 4'h0);
		expect_rd("pc", `ADDR_PC, {16'h0, t});
		set_ip(q);
		exec(exec_pkg::op_jump_ip, 4'h0, 4'h0, 8'h00, 1'b0, 4'h0);
		expect_rd("pc", `ADDR_PC, {16'h0, q});
		for (int k = 0; k < 16; k++)
		begin
			r = $random(seed);
			wr(`ADDR_FLAGS, {29'h0, r[2:0]});
			wr(`ADDR_PC, {16'h0, p});
			exec(k[0] ? exec_pkg::op_jcc_ip : exec_pkg::op_jcc, 4'h0, 4'h0,
				8'h00, 1'b0, 4'(k));
			expect_rd("jcc pc", `ADDR_PC, {16'h0, cond_true(4'(k), r[2:0]) ?
				(k[0] ? q : t) : p + 16'h0001});
		end
		wr(`ADDR_PC, {16'h0, p});
		exec(exec_pkg::op_call, 4'h0, 4'h0, 8'h00, 1'b0, 4'h0);
		expect_rd("pc", `ADDR_PC, {16'h0, t});
		exec(exec_pkg::op_call_ip, 4'h0, 4'h0, 8'h00, 1'b0, 4'h0);
		expect_rd("pc", `ADDR_PC, {16'h0, q});
		expect_rd("stack", `ADDR_STACK, {16'h0, t + 16'h0001});
		wr(reg_addr(`IDX_STAT), 32'h0);
		wr(reg_addr(`IDX_ACC), {24'h0, r[15:8]});
		wr(`ADDR_FLAGS, {29'h0, r[2:0]});
		exec(exec_pkg::op_ret, 4'h0, 4'h0, 8'h00, 1'b0, 4'h0);
		expect_rd("pc", `ADDR_PC, {16'h0, t + 16'h0001});
		expect_rd("stack", `ADDR_STACK, {16'h0, p + 16'h0001});
		expect_rd("flags", `ADDR_FLAGS,
			{16'h0, r[15:8], 5'h0, r[2:0]});
		exec(exec_pkg::op_reti, 4'h0, 4'h0, 8'h00, 1'b0, 4'h0);
		expect_rd("pc", `ADDR_PC, {16'h0, p + 16'h0001});
		expect_rd("status", reg_addr(`IDX_STAT), 32'h1 << `GIE_BIT);
		wr(`ADDR_PC, {16'h0, p});
		exec(exec_pkg::op_calls, 4'h0, 4'h0, 8'h00, 1'b0, 4'h0);
		expect_rd("pc", `ADDR_PC, {16'h0, t});
		expect_ip(p + 16'h0001);
		exec(exec_pkg::op_rets, 4'h0, 4'h0, 8'h00, 1'b0, 4'h0);
		expect_rd("pc", `ADDR_PC, {16'h0, p + 16'h0001});
		set_ip(q);
		exec(exec_pkg::op_calls_ip, 4'h0, 4'h0, 8'h00, 1'b0, 4'h0);
		expect_rd("pc", `ADDR_PC, {16'h0, q});
		// The link is the address after the current PC, which rets left at p+1
		expect_ip(p + 16'h0002);
		// Nine pushes overrun the eight levels, so the last pop gives zero
		wr(`ADDR_PC, {16'h0, p});
		for (int i = 0; i < 9; i++)
		begin
			r = $random(seed);
			vals[i] = r[15:0];
			set_ip(vals[i]);
			exec(exec_pkg::op_push, 4'h0, 4'h0, 8'h00, 1'b0, 4'h0);
			expect_rd("stack", `ADDR_STACK, {16'h0, vals[i]});
		end
		expect_rd("pc", `ADDR_PC, {16'h0, p + 16'h0009});
		for (int i = 0; i < 9; i++)
		begin
			exec(exec_pkg::op_pop, 4'h0, 4'h0, 8'h00, 1'b0, 4'h0);
			expect_ip(i < 8 ? vals[8 - i] : 16'h0000);
		end
		expect_rd("pc", `ADDR_PC, {16'h0, p + 16'h0012});
		r = $random(seed);
		wr(`ADDR_FLAGS, 32'h6);
		exec(exec_pkg::op_move_imm, 4'h5, 4'h0, r[7:0], 1'b0, 4'h0);
		expect_rd("reg", reg_addr(5), {24'h0, r[7:0]});
		expect_rd("flags", `ADDR_FLAGS,
			{16'h0, r[7:0], 5'h0, 2'b11, r[7:0] == 8'h00});
		wr(`ADDR_FLAGS, 32'h5);
		exec(exec_pkg::op_move_to_dm, 4'h5, 4'h0, r[15:8], 1'b0, 4'h0);
		expect_rd("store", `ADDR_DMSTORE, {16'h0, r[15:8], r[7:0]});
		wr(`ADDR_TARGET, {24'h0, r[23:16]});
		exec(exec_pkg::op_move_imm_dm, 4'h0, 4'h0, r[31:24], 1'b0, 4'h0);
		expect_rd("store", `ADDR_DMSTORE, {16'h0, r[23:16], r[31:24]});
		expect_rd("flags", `ADDR_FLAGS,
			{16'h0, r[7:0], 5'h0, 3'b101});
		// Three moves and a no-op each advance PC by one past the pops
		exec(exec_pkg::op_nop, 4'h0, 4'h0, 8'h00, 1'b0, 4'h0);
		expect_rd("pc", `ADDR_PC, {16'h0, p + 16'h0016});
		final_report();
	end

endmodule
`default_nettype wire
